// ### logic/dwl_regs.svh
`ifndef DWL_REGS_SVH
`define DWL_REGS_SVH

// pin and bus widths
`define DWL_ADDR_W        14
`define DWL_BA_W          3
`define DWL_LANES         2
`define DWL_LANE_W        8
`define DWL_REG_AW        8
`define DWL_REG_DW        32
`define DWL_CNT_W         12
`define DWL_SRE_W         8

// mode-register select on the bank address
`define DWL_MR0_SEL       3'h0
`define DWL_MR1_SEL       3'h1

// mode-register bit positions
`define DWL_MR0_DLL_RST   8
`define DWL_MR1_DLL_DIS   0
`define DWL_MR1_RTT0      2
`define DWL_MR1_RTT1      6
`define DWL_MR1_WLEV      7
`define DWL_MR1_RTT2      9
`define DWL_MR1_QOFF      12

// register offsets (byte addresses)
`define DWL_OFS_STATUS    8'h00
`define DWL_OFS_MR0       8'h04
`define DWL_OFS_MR1       8'h08
`define DWL_OFS_ERR       8'h0c
`define DWL_OFS_DLLK      8'h10

// status field positions
`define DWL_ST_PWR_LSB    0
`define DWL_ST_CLK_FREE   2
`define DWL_ST_DLL_EN     3
`define DWL_ST_LOCKED     4
`define DWL_ST_RELOCK     5
`define DWL_ST_WLEV       6
`define DWL_ST_QOFF       7

// error field positions
`define DWL_ERR_WL_CMD    0
`define DWL_ERR_RL_CKE    1
`define DWL_ERR_RL_ODT    2

// reset values
`define DWL_MR_RST        14'h0000
`define DWL_ERR_RST       3'h0
`define DWL_DLLK_TCK      512

// timing
`define DWL_TCK_NS        10
`define DWL_CKSRE_NS      10
`define DWL_CKSRE_CYC     ((`DWL_CKSRE_NS + `DWL_TCK_NS - 1) / `DWL_TCK_NS)
`define DWL_WLO_NS        9
`define DWL_WLO_CYC       (((`DWL_WLO_NS / `DWL_TCK_NS) < 1) ? 1 : \
                           (`DWL_WLO_NS / `DWL_TCK_NS))

`endif

// ### logic/dwl_pkg.sv
`include "dwl_regs.svh"

package dwl_pkg;

   // one command slot as registered on a clock edge
   typedef struct packed
   {
      logic                     cs_n;
      logic                     ras_n;
      logic                     cas_n;
      logic                     we_n;
      logic [`DWL_BA_W-1:0]     ba;
      logic [`DWL_ADDR_W-1:0]   addr;
   } dwl_cmd_type;

   // termination switches
   typedef struct packed
   {
      logic                     dqs_on;
      logic                     dq_on;
   } dwl_term_type;

   // power state, gray along idle -> sref and idle -> ppd
   typedef enum logic [1:0]
   {
      PWR_IDLE = 2'b00,
      PWR_SREF = 2'b01,
      PWR_PPD  = 2'b10
   } dwl_pwr_type;

endpackage

// ### logic/dwl_lane_fb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dwl_regs.svh"

module dwl_lane_fb
(
   // clock and reset
   input  wire logic                   clk_in,
   input  wire logic                   rst_in,
   // leveling control
   input  wire logic                   enable_in,
   input  wire logic                   ck_level_in,
   input  wire logic [`DWL_LANES-1:0]  dqs_rise_in,
   // feedback per lane
   output logic      [`DWL_LANES-1:0]  fb_out,
   output logic      [`DWL_LANES-1:0]  drive_out
);
   import dwl_pkg::*;

   localparam int DEPTH = `DWL_WLO_CYC;

   genvar ln;
   generate
      for (ln = 0; ln < `DWL_LANES; ln = ln + 1)
      begin : g_lane
         logic [DEPTH-1:0] lvl_q;
         logic [DEPTH-1:0] drv_q;
         logic [DEPTH-1:0] lvl_d;
         logic [DEPTH-1:0] drv_d;

         // stage 0 holds the clock level caught on this lane's strobe
         assign lvl_d[0] = dqs_rise_in[ln] ? ck_level_in : lvl_q[0];
         assign drv_d[0] = drv_q[0] | dqs_rise_in[ln];
         if (DEPTH > 1)
         begin : g_shift
            // held value walks out so the pins follow within the delay
            assign lvl_d[DEPTH-1:1] = lvl_q[DEPTH-2:0];
            assign drv_d[DEPTH-1:1] = drv_q[DEPTH-2:0];
         end

         // leaving leveling or disabled buffers drop the lane at once
         always_ff @(posedge clk_in or posedge rst_in)
         begin
            if (rst_in)
            begin
               lvl_q <= '0;
               drv_q <= '0;
            end
            else if (!enable_in)
            begin
               lvl_q <= '0;
               drv_q <= '0;
            end
            else
            begin
               lvl_q <= lvl_d;
               drv_q <= drv_d;
            end
         end

         assign fb_out[ln]    = lvl_q[DEPTH-1];
         assign drive_out[ln] = drv_q[DEPTH-1];
      end
   endgenerate

endmodule

`default_nettype wire

// ### logic/dwl_mode_ctrl.sv
// Overview of operation
// - mode register 0 write with A8 set starts dll reset and relock
// - in self-refresh after tCKSRE the device ignores the clock
// - mode register 1 A7 set enters write leveling, clear leaves it
// - in leveling ODT switches strobe termination only, data stays off
// - mode register 1 A12 set disables outputs; other ranks set it
// - leveling: data pins undefined, only nop, deselect, mode write
// - each strobe rise samples clock level onto data within tWLO
// - each byte lane reports its own strobe pair against the clock
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dwl_regs.svh"

module dwl_mode_ctrl
(
   // clock and reset
   input  wire logic                       CLK_IN,
   input  wire logic                       RST_IN,
   // memory command pins
   input  wire logic                       CKE_IN,
   input  wire logic                       ODT_IN,
   input  wire dwl_pkg::dwl_cmd_type       CMD_IN,
   // leveling inputs
   input  wire logic                       CK_LEVEL_IN,
   input  wire logic [`DWL_LANES-1:0]      DQS_RISE_IN,
   // register port
   input  wire logic [`DWL_REG_AW-1:0]     REG_ADDR_IN,
   input  wire logic [`DWL_REG_DW-1:0]     REG_WDATA_IN,
   input  wire logic                       REG_WR_IN,
   input  wire logic                       REG_RD_IN,
   output logic      [`DWL_REG_DW-1:0]     REG_RDATA_OUT,
   // data pins during leveling
   output logic      [`DWL_LANES*`DWL_LANE_W-1:0] DQ_OUT,
   output logic      [`DWL_LANES-1:0]      DQ_OE_OUT,
   // device state
   output dwl_pkg::dwl_term_type           TERM_OUT,
   output logic                            DLL_LOCKED_OUT,
   output logic                            FREQ_CHANGE_OK_OUT,
   output logic                            WL_MODE_OUT
);
   import dwl_pkg::*;

   localparam logic [`DWL_SRE_W-1:0] SRE_CYC = `DWL_SRE_W'(`DWL_CKSRE_CYC);
   localparam logic [`DWL_CNT_W-1:0] DLLK_RST = `DWL_CNT_W'(`DWL_DLLK_TCK);

   dwl_pwr_type               pwr_q;
   dwl_pwr_type               pwr_d;
   logic                      cke_q;
   logic [`DWL_SRE_W-1:0]     sre_cnt_q;
   logic                      clk_free_q;
   logic [`DWL_ADDR_W-1:0]    mr0_q;
   logic [`DWL_ADDR_W-1:0]    mr1_q;
   logic                      relock_q;
   logic                      locked_q;
   logic [`DWL_CNT_W-1:0]     lock_cnt_q;
   logic [`DWL_CNT_W-1:0]     dllk_cfg_q;
   logic                      odt_feat_q;
   logic [2:0]                err_q;
   logic [2:0]                err_d;
   logic [2:0]                err_set;
   logic [`DWL_REG_DW-1:0]    rdata_q;
   dwl_term_type              term_q;
   dwl_term_type              term_d;
   logic [`DWL_LANES-1:0]     fb;
   logic [`DWL_LANES-1:0]     fb_drive;

   // command decode; a command only counts while CKE stays high
   wire cmd_live  = cke_q & CKE_IN & ~CMD_IN.cs_n;
   wire is_mrs    = ~CMD_IN.ras_n & ~CMD_IN.cas_n & ~CMD_IN.we_n;
   wire is_ref    = ~CMD_IN.ras_n & ~CMD_IN.cas_n &  CMD_IN.we_n;
   wire is_nop    =  CMD_IN.ras_n &  CMD_IN.cas_n &  CMD_IN.we_n;
   wire cke_fall  =  cke_q & ~CKE_IN;
   wire cke_rise  = ~cke_q &  CKE_IN;
   wire in_idle   = (pwr_q == PWR_IDLE);
   wire mrs_ok    = cmd_live & is_mrs & in_idle;
   wire mr0_wr    = mrs_ok & (CMD_IN.ba == `DWL_MR0_SEL);
   wire mr1_wr    = mrs_ok & (CMD_IN.ba == `DWL_MR1_SEL);

   // mode-register views
   wire dll_en    = ~mr1_q[`DWL_MR1_DLL_DIS];
   wire wl_mode   =  mr1_q[`DWL_MR1_WLEV];
   wire qoff      =  mr1_q[`DWL_MR1_QOFF];
   wire rtt_nom   =  mr1_q[`DWL_MR1_RTT0] | mr1_q[`DWL_MR1_RTT1] |
                     mr1_q[`DWL_MR1_RTT2];
   wire dll_dis_w = mr1_wr & CMD_IN.addr[`DWL_MR1_DLL_DIS];
   wire dll_en_w  = mr1_wr ? ~CMD_IN.addr[`DWL_MR1_DLL_DIS] : dll_en;
   wire dll_rst   = mr0_wr & CMD_IN.addr[`DWL_MR0_DLL_RST] & dll_en_w;

   // power state; banks are assumed closed on entry by the controller
   always_comb
   begin
      pwr_d = pwr_q;
      unique case (pwr_q)
         PWR_IDLE:
         begin
            if (cke_fall && !CMD_IN.cs_n && is_ref)
               pwr_d = PWR_SREF;
            else if (cke_fall && (CMD_IN.cs_n || is_nop))
               pwr_d = PWR_PPD;
         end
         PWR_SREF:
         begin
            if (cke_rise)
               pwr_d = PWR_IDLE;
         end
         PWR_PPD:
         begin
            if (cke_rise)
               pwr_d = PWR_IDLE;
         end
         default:
            pwr_d = PWR_IDLE;
      endcase
   end

   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         pwr_q <= PWR_IDLE;
         cke_q <= 1'b0;
      end
      else
      begin
         pwr_q <= pwr_d;
         cke_q <= CKE_IN;
      end
   end

   // count tCKSRE after low-power entry; past it the clock is don't-care
   wire sre_done = (sre_cnt_q >= SRE_CYC);
   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         sre_cnt_q  <= '0;
         clk_free_q <= 1'b0;
      end
      else if (pwr_d == PWR_IDLE)
      begin
         sre_cnt_q  <= '0;
         clk_free_q <= 1'b0;
      end
      else
      begin
         if (!sre_done)
            sre_cnt_q <= sre_cnt_q + 1'b1;
         clk_free_q <= sre_done;
      end
   end

   // mode-register shadows; writes outside idle are not registered
   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         mr0_q <= `DWL_MR_RST;
         mr1_q <= `DWL_MR_RST;
      end
      else
      begin
         if (mr0_wr)
            mr0_q <= CMD_IN.addr;
         if (mr1_wr)
            mr1_q <= CMD_IN.addr;
      end
   end

   // dll relock; a clock that may have moved always forces a new reset
   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         relock_q   <= 1'b0;
         locked_q   <= 1'b0;
         lock_cnt_q <= '0;
      end
      else if (dll_dis_w || clk_free_q)
      begin
         relock_q   <= 1'b0;
         locked_q   <= 1'b0;
      end
      else if (dll_rst)
      begin
         relock_q   <= 1'b1;
         locked_q   <= 1'b0;
         lock_cnt_q <= dllk_cfg_q;
      end
      else if (relock_q && lock_cnt_q == '0)
      begin
         relock_q   <= 1'b0;
         locked_q   <= 1'b1;
      end
      else if (relock_q)
         lock_cnt_q <= lock_cnt_q - 1'b1;
   end

   // termination features captured at low-power entry
   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
         odt_feat_q <= 1'b0;
      else if (in_idle && pwr_d != PWR_IDLE)
         odt_feat_q <= rtt_nom;
   end

   // protocol violations the device can see; set wins over clear
   assign err_set[`DWL_ERR_WL_CMD] = wl_mode & cmd_live &
                                     ~(is_nop | is_mrs);
   assign err_set[`DWL_ERR_RL_CKE] = relock_q & cke_fall;
   assign err_set[`DWL_ERR_RL_ODT] = relock_q & odt_feat_q & ODT_IN;
   wire   err_clr = REG_WR_IN & (REG_ADDR_IN == `DWL_OFS_ERR);
   assign err_d   = (err_q & ~(err_clr ? REG_WDATA_IN[2:0] : 3'h0)) | err_set;

   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
         err_q <= `DWL_ERR_RST;
      else
         err_q <= err_d;
   end

   // lock time in clock cycles, software may retune it
   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
         dllk_cfg_q <= DLLK_RST;
      else if (REG_WR_IN && REG_ADDR_IN == `DWL_OFS_DLLK)
         dllk_cfg_q <= REG_WDATA_IN[`DWL_CNT_W-1:0];
   end

   // termination: leveling switches only the strobe pair, none in sref
   assign term_d.dqs_on = (pwr_q == PWR_SREF) ? 1'b0 :
                          wl_mode ? ODT_IN : (ODT_IN & rtt_nom);
   assign term_d.dq_on  = (pwr_q == PWR_SREF) ? 1'b0 :
                          wl_mode ? 1'b0 : (ODT_IN & rtt_nom);

   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
         term_q <= '0;
      else
         term_q <= term_d;
   end

   // feedback lanes; disabled outputs keep a quiet rank off the bus
   wire fb_en = wl_mode & ~qoff & in_idle;

   dwl_lane_fb u_lane_fb
   (
      .clk_in      (CLK_IN),
      .rst_in      (RST_IN),
      .enable_in   (fb_en),
      .ck_level_in (CK_LEVEL_IN),
      .dqs_rise_in (DQS_RISE_IN),
      .fb_out      (fb),
      .drive_out   (fb_drive)
   );

   // register read select; unmapped offsets read zero
   wire [`DWL_REG_DW-1:0] st_word =
      {24'h000000, qoff, wl_mode, relock_q, locked_q, dll_en,
       clk_free_q, pwr_q};
   wire [`DWL_REG_DW-1:0] rd_sel =
      (REG_ADDR_IN == `DWL_OFS_STATUS) ? st_word :
      (REG_ADDR_IN == `DWL_OFS_MR0)    ? {18'h00000, mr0_q} :
      (REG_ADDR_IN == `DWL_OFS_MR1)    ? {18'h00000, mr1_q} :
      (REG_ADDR_IN == `DWL_OFS_ERR)    ? {29'h00000000, err_q} :
      (REG_ADDR_IN == `DWL_OFS_DLLK)   ? {20'h00000, dllk_cfg_q} :
                                         32'h00000000;

   // read data stand for one cycle only
   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
         rdata_q <= '0;
      else
         rdata_q <= REG_RD_IN ? rd_sel : 32'h00000000;
   end

   assign REG_RDATA_OUT      = rdata_q;
   assign DQ_OUT             = {{`DWL_LANE_W{fb[1]}}, {`DWL_LANE_W{fb[0]}}};
   assign DQ_OE_OUT          = fb_drive;
   assign TERM_OUT           = term_q;
   assign DLL_LOCKED_OUT     = locked_q;
   assign FREQ_CHANGE_OK_OUT = clk_free_q;
   assign WL_MODE_OUT        = mr1_q[`DWL_MR1_WLEV];

endmodule

`default_nettype wire

// ### sim/dwl_mode_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "dwl_regs.svh"

module dwl_mode_ctrl_chk
(
   // clock and reset
   input wire logic                 CLK_IN,
   input wire logic                 RST_IN,
   // command and leveling pins
   input wire logic                 CKE_IN,
   input wire logic                 ODT_IN,
   input wire dwl_pkg::dwl_cmd_type CMD_IN,
   input wire logic                 CK_LEVEL_IN,
   input wire logic [1:0]           DQS_RISE_IN,
   // device outputs
   input wire logic [15:0]          DQ_OUT,
   input wire logic [1:0]           DQ_OE_OUT,
   input wire dwl_pkg::dwl_term_type TERM_OUT,
   input wire logic                 DLL_LOCKED_OUT,
   input wire logic                 FREQ_CHANGE_OK_OUT,
   input wire logic                 WL_MODE_OUT
);
   import dwl_pkg::*;
   logic cke_q;
   logic qoff_q;
   logic dll_off_q;

   // decode; a command counts only on two high CKE edges in a row
   wire logic taken = cke_q & CKE_IN & ~CMD_IN.cs_n;
   wire logic mrs = taken & ~CMD_IN.ras_n & ~CMD_IN.cas_n & ~CMD_IN.we_n;
   wire logic mr1 = mrs & (CMD_IN.ba == `DWL_MR1_SEL);
   wire logic mr0 = mrs & (CMD_IN.ba == `DWL_MR0_SEL);
   wire logic fb_en = WL_MODE_OUT & ~qoff_q & cke_q & CKE_IN;
   wire logic sre = cke_q & ~CKE_IN & ~CMD_IN.cs_n & ~CMD_IN.ras_n &
                    ~CMD_IN.cas_n & CMD_IN.we_n;

   // mode bits the properties need, mirrored from the mode writes
   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         cke_q     <= 1'b0;
         qoff_q    <= 1'b0;
         dll_off_q <= 1'b0;
      end
      else
      begin
         cke_q <= CKE_IN;
         if (mr1)
         begin
            qoff_q    <= CMD_IN.addr[`DWL_MR1_QOFF];
            dll_off_q <= CMD_IN.addr[`DWL_MR1_DLL_DIS];
         end
      end
   end

   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);

   property p_wl_on;
      mr1 && CMD_IN.addr[`DWL_MR1_WLEV] |=> WL_MODE_OUT;
   endproperty
   a_wl_on: assert property (p_wl_on)
      else $error("leveling mode not entered");

   property p_oe_quiet;
      !WL_MODE_OUT |=> DQ_OE_OUT == 2'b00;
   endproperty
   a_oe_quiet: assert property (p_oe_quiet)
      else $error("data driven outside leveling");

   property p_term_wl;
      WL_MODE_OUT |=> TERM_OUT.dqs_on == $past(ODT_IN) && !TERM_OUT.dq_on;
   endproperty
   a_term_wl: assert property (p_term_wl)
      else $error("leveling termination wrong");

   property p_fb_lo;
      fb_en && DQS_RISE_IN[0] |=>
         DQ_OE_OUT[0] && DQ_OUT[7:0] == {8{$past(CK_LEVEL_IN)}};
   endproperty
   a_fb_lo: assert property (p_fb_lo)
      else $error("lower lane feedback wrong");

   property p_fb_hi;
      fb_en && DQS_RISE_IN[1] |=>
         DQ_OE_OUT[1] && DQ_OUT[15:8] == {8{$past(CK_LEVEL_IN)}};
   endproperty
   a_fb_hi: assert property (p_fb_hi)
      else $error("upper lane feedback wrong");

   property p_qoff_hold;
      WL_MODE_OUT && qoff_q && DQS_RISE_IN != 2'b00 |=>
         $stable(DQ_OUT) && $stable(DQ_OE_OUT);
   endproperty
   a_qoff_hold: assert property (p_qoff_hold)
      else $error("disabled outputs answered a strobe");

   property p_relock;
      mr0 && CMD_IN.addr[`DWL_MR0_DLL_RST] && !dll_off_q |=>
         !DLL_LOCKED_OUT [*2];
   endproperty
   a_relock: assert property (p_relock)
      else $error("dll reset did not drop lock");

   property p_sref_flag;
      sre ##1 !CKE_IN [*3] |=> FREQ_CHANGE_OK_OUT;
   endproperty
   a_sref_flag: assert property (p_sref_flag)
      else $error("clock not free in self-refresh");

   // main scenarios reached
   c_fb: cover property (fb_en && DQS_RISE_IN != 2'b00);
   c_sref: cover property (sre);
   c_lock: cover property ($rose(DLL_LOCKED_OUT));
endmodule
`default_nettype wire

// ### sim/dwl_ctl.sv
`timescale 1ns/1ps
`default_nettype none

module dwl_ctl
(
   // device clock
   input  wire logic                 clk_in,
   // pins toward the device
   output var  logic                 cke_out,
   output var  logic                 odt_out,
   output var  dwl_pkg::dwl_cmd_type cmd_out,
   output var  logic                 ck_level_out,
   output var  logic [1:0]           dqs_rise_out
);
   import dwl_pkg::*;

   // quiet pins at power-up: deselected, termination low, no strobe
   initial
   begin
      cke_out      = 1'b1;
      odt_out      = 1'b0;
      cmd_out      = '1;
      ck_level_out = 1'b0;
      dqs_rise_out = 2'b00;
   end

   // one command slot with a new CKE level; the next slot deselects and
   // inverts the address so a stale address never looks held
   task automatic issue(input logic k, input logic [3:0] c,
                        input logic [2:0] b, input logic [13:0] a);
      @(posedge clk_in);
      cke_out <= k;
      cmd_out <= {c, b, a};
      @(posedge clk_in);
      cmd_out <= {4'hf, b, ~a};
   endtask

   // termination pin, moved just after an edge
   task automatic term(input logic v);
      @(posedge clk_in);
      odt_out <= v;
   endtask

   // one rising strobe per chosen lane, clock level sampled with it
   task automatic strobe(input logic [1:0] l, input logic v);
      @(posedge clk_in);
      dqs_rise_out <= l;
      ck_level_out <= v;
      @(posedge clk_in);
      dqs_rise_out <= 2'b00;
      ck_level_out <= ~v;
   endtask
endmodule
`default_nettype wire

// ### sim/test_dwl_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "dwl_regs.svh"

module test_dwl_mode_ctrl;
   import dwl_pkg::*;
   // clock, reset, register port
   realtime      half = 5.0;
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   logic [7:0]   raddr = 8'h00;
   logic [31:0]  wdata = 32'h0;
   logic         wr = 1'b0;
   logic         rd = 1'b0;
   // pins and outputs
   logic         cke;
   logic         odt;
   dwl_cmd_type  cmd;
   logic         lvl;
   logic [1:0]   dqs;
   logic [31:0]  rdata;
   logic [15:0]  dq;
   logic [1:0]   oe;
   dwl_term_type term;
   logic         locked;
   logic         fok;
   logic         wl;
   // expectations and counters
   logic [15:0]  exp_dq = 16'h0;
   logic [1:0]   exp_oe = 2'b00;
   logic [1:0]   ln;
   logic         v;
   int           n_fail = 0;
   int           cmp_count = 0;

   always #(half) clk = ~clk;

   dwl_ctl u_dwl_ctl
   (
      .clk_in(clk), .cke_out(cke), .odt_out(odt), .cmd_out(cmd),
      .ck_level_out(lvl), .dqs_rise_out(dqs)
   );

   dwl_mode_ctrl u_dwl_mode_ctrl
   (
      .CLK_IN(clk), .RST_IN(rst), .CKE_IN(cke), .ODT_IN(odt),
      .CMD_IN(cmd), .CK_LEVEL_IN(lvl), .DQS_RISE_IN(dqs),
      .REG_ADDR_IN(raddr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr),
      .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .DQ_OUT(dq),
      .DQ_OE_OUT(oe), .TERM_OUT(term), .DLL_LOCKED_OUT(locked),
      .FREQ_CHANGE_OK_OUT(fok), .WL_MODE_OUT(wl)
   );

   // feedback expected once the lanes in l saw a strobe at level s
   function automatic logic [15:0] fb_exp(input logic [15:0] o,
      input logic [1:0] l, input logic s);
      for (int i = 0; i < 2; i++)
         if (l[i])
            o[8*i +: 8] = {8{s}};
      return o;
   endfunction

   // one comparison; case inequality lets no unknown through
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      raddr <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e);
      @(posedge clk);
      raddr <= a;
      rd    <= 1'b1;
      @(posedge clk);
      rd    <= 1'b0;
      #1;
      check(rdata & m, e);
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // hang guard, far beyond the hundred-odd cycles of the sequence
   initial
   begin
      #50000;
      n_fail++;
      report_and_stop();
   end

   initial
   begin
      void'($urandom(4));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      // reset values, a read-only write, a hole, a short lock time
      reg_wr(`DWL_OFS_MR0, 32'hffffffff);
      reg_rd(`DWL_OFS_MR0, '1, 32'h0);
      reg_rd(`DWL_OFS_ERR, '1, 32'h0);
      reg_rd(`DWL_OFS_DLLK, '1, 32'h200);
      reg_rd(8'h14, '1, 32'h0);
      reg_wr(`DWL_OFS_DLLK, {20'($urandom()), 12'h004});
      reg_rd(`DWL_OFS_DLLK, '1, 32'h4);
      // leveling, outputs on, nominal termination of a quarter
      u_dwl_ctl.issue(1'b1, 4'h0, 3'h1, 14'h0084);
      tick(1);
      check(wl, 1'b1);
      check(oe, 2'b00);
      u_dwl_ctl.term(1'b1);
      tick(1);
      check(term, 2'b10);
      repeat (8)
      begin
         ln = 2'($urandom_range(3, 1));
         v = 1'($urandom());
         u_dwl_ctl.strobe(ln, v);
         exp_dq = fb_exp(exp_dq, ln, v);
         exp_oe = exp_oe | ln;
         tick(1);
         check(dq, exp_dq);
         check(oe, exp_oe);
      end
      // a row command is refused in leveling and flagged
      u_dwl_ctl.issue(1'b1, 4'h3, 3'h0, 14'h0000);
      reg_rd(`DWL_OFS_ERR, 32'h1, 32'h1);
      reg_wr(`DWL_OFS_ERR, 32'h1);
      reg_rd(`DWL_OFS_ERR, 32'h1, 32'h0);
      // outputs disabled: strobes leave the data pins alone
      u_dwl_ctl.term(1'b0);
      u_dwl_ctl.issue(1'b1, 4'h0, 3'h1, 14'h1084);
      u_dwl_ctl.strobe(2'b11, ~exp_dq[0]);
      tick(1);
      check(dq, 16'h0000);
      check(oe, 2'b00);
      u_dwl_ctl.issue(1'b1, 4'h0, 3'h1, 14'h0000);
      tick(1);
      check(wl, 1'b0);
      check(oe, 2'b00);
      // self-refresh with the clock moved while it is free
      u_dwl_ctl.issue(1'b0, 4'h1, 3'h0, 14'h0000);
      tick(4);
      check(fok, 1'b1);
      reg_rd(`DWL_OFS_STATUS, 32'h3, 32'h1);
      half = 4.0;
      tick(4);
      half = 5.0;
      tick(4);
      u_dwl_ctl.issue(1'b1, 4'h7, 3'h0, 14'h0000);
      tick(1);
      check(fok, 1'b0);
      tick(4);
      u_dwl_ctl.issue(1'b1, 4'h0, 3'h1, 14'h0000);
      u_dwl_ctl.issue(1'b1, 4'h0, 3'h0, 14'h0100);
      tick(4);
      check(locked, 1'b0);
      tick(1);
      check(locked, 1'b1);
      // precharge power-down, then a fresh dll reset
      u_dwl_ctl.issue(1'b0, 4'h7, 3'h0, 14'h0000);
      tick(4);
      check(fok, 1'b1);
      reg_rd(`DWL_OFS_STATUS, 32'h3, 32'h2);
      u_dwl_ctl.issue(1'b1, 4'h7, 3'h0, 14'h0000);
      tick(1);
      check(fok, 1'b0);
      u_dwl_ctl.issue(1'b1, 4'h0, 3'h0, 14'h0100);
      tick(8);
      check(locked, 1'b1);
      reg_rd(`DWL_OFS_STATUS, 32'h18, 32'h18);
      reg_rd(`DWL_OFS_ERR, '1, 32'h0);
      report_and_stop();
   end
endmodule

bind dwl_mode_ctrl dwl_mode_ctrl_chk u_dwl_mode_ctrl_chk
(
   .CLK_IN(CLK_IN), .RST_IN(RST_IN), .CKE_IN(CKE_IN), .ODT_IN(ODT_IN),
   .CMD_IN(CMD_IN), .CK_LEVEL_IN(CK_LEVEL_IN), .DQS_RISE_IN(DQS_RISE_IN),
   .DQ_OUT(DQ_OUT), .DQ_OE_OUT(DQ_OE_OUT), .TERM_OUT(TERM_OUT),
   .DLL_LOCKED_OUT(DLL_LOCKED_OUT), .WL_MODE_OUT(WL_MODE_OUT),
   .FREQ_CHANGE_OK_OUT(FREQ_CHANGE_OK_OUT)
);
`default_nettype wire
